// file: uart_frame_core.sv
// Purpose: async serial port core: frame format, baud timing, sampling, byte buffers
// Assumes: avalon-mm slave with waitrequest, word index on avs_address_i, 8-bit data
// Notes:   status, interrupts, dma and flow control live elsewhere
// Contract
// - second divider stage divides by eleven-bit divisor plus one, split over two registers.
// - char length 00=8, 01=7, 10=9 bits, 11=loop-back with 9 bits.
// - stop-count bit 0 sends one stop bit, 1 sends two.
// - parity enable adds and checks parity, ignored in nine-bit frames.
// - reset clears frame format; divisor low register keeps contents through reset.
// - sample position used only in manual mode; resets to 06h.
// - three consecutive samples per bit, first at programmed index from 0.
// - automatic start index is 2,3,4,5,6 for rates 7-8 up to 15-16.
// - oversample codes 0-6 give sixteen, codes 7-15 give the code value.
// - reset clears oversample register, giving sixteen-times oversampling.
// - bit rate is clock over oversample rate times divisor-plus-one times prescaler.
// - prescaler supports half-integer factors for fine baud adjustment.
// - each received byte sits in a read-only eight-bit receive buffer.
// - transmit buffer is eight-bit read-write; writing it sends the byte.
// - manual sample mode 0 places samples automatically, 1 uses sample position.
// - prescaler register holds five-bit prescaler code plus divisor bits ten to eight.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg.svh"
module uart_frame_core (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        rxd_i,
    output logic             txd_o,
    output logic             tx_busy_o,
    output logic             rx_done_o,
    output logic             rx_parity_err_o,
    output logic             rx_frame_err_o
);
    // rate 7..16 from the four-bit code
    function automatic logic [4:0] os_rate(input logic [3:0] code);
        os_rate = (code < `OVR_MIN_CODE) ? `OVR_DEFAULT_RATE : {1'b0, code};
    endfunction

    // parity over the active data bits of a frame
    function automatic logic par_bit(input logic [8:0] data, input logic [3:0] nbits,
                                     input logic [1:0] psel);
        logic [8:0] mask;
        logic       ones;
        mask = 9'h1ff >> (4'h9 - nbits);
        ones = ^(data & mask);
        if (psel == `PAR_ODD)
            par_bit = ~ones;
        else if (psel == `PAR_EVEN)
            par_bit = ones;
        else if (psel == `PAR_MARK)
            par_bit = 1'b1;
        else
            par_bit = 1'b0;
    endfunction

    // ---------------- registers ----------------
    logic [7:0] baud_low_r;
    logic [7:0] prescaler_r;
    logic [6:0] frame_format_r;
    logic [3:0] sample_pos_r;
    logic [3:0] oversample_r;
    logic       manual_mode_r;
    logic [7:0] rx_buf_r;
    logic [7:0] tx_buf_r;
    logic       ack_r;
    logic [7:0] rdata_r;

    wire access  = avs_read_i | avs_write_i;
    wire wr_take = avs_write_i & ack_r;
    wire wr_baud = wr_take && (avs_address_i == `REG_BAUD_LOW);
    wire wr_psr  = wr_take && (avs_address_i == `REG_PRESCALER);
    wire wr_frs  = wr_take && (avs_address_i == `REG_FRAME);
    wire wr_spos = wr_take && (avs_address_i == `REG_SAMPLE_POS);
    wire wr_ovr  = wr_take && (avs_address_i == `REG_OVERSAMPLE);
    wire wr_mod2 = wr_take && (avs_address_i == `REG_MODE_TWO);
    wire wr_tbuf = wr_take && (avs_address_i == `REG_TX_BUF);
    wire [7:0] wdata = avs_writedata_i[7:0];

    // unmapped indices read zero and ignore writes
    wire [7:0] rd_mux =
        (avs_address_i == `REG_BAUD_LOW)   ? baud_low_r :
        (avs_address_i == `REG_PRESCALER)  ? prescaler_r :
        (avs_address_i == `REG_FRAME)      ? {1'b0, frame_format_r} :
        (avs_address_i == `REG_SAMPLE_POS) ? {4'h0, sample_pos_r} :
        (avs_address_i == `REG_OVERSAMPLE) ? {4'h0, oversample_r} :
        (avs_address_i == `REG_MODE_TWO)   ? {7'h00, manual_mode_r} :
        (avs_address_i == `REG_RX_BUF)     ? rx_buf_r :
        (avs_address_i == `REG_TX_BUF)     ? tx_buf_r : 8'h00;

    // one wait state: the answer stands at the edge where waitrequest is low
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= access & ~ack_r;
            if (avs_read_i & ~ack_r)
                rdata_r <= rd_mux;
        end
    end

    assign avs_waitrequest_o = access & ~ack_r;
    assign avs_readdata_o    = {24'h000000, rdata_r};

    // no reset on purpose: contents survive a reset
    always_ff @(posedge clk_sys_i) begin
        if (wr_baud)
            baud_low_r <= wdata;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prescaler_r    <= `PSR_RESET;
            frame_format_r <= `FRS_RESET;
            sample_pos_r   <= `SPOS_RESET;
            oversample_r   <= `OVR_RESET;
            manual_mode_r  <= `MODE_TWO_RESET;
            tx_buf_r       <= 8'h00;
        end else begin
            if (wr_psr)
                prescaler_r <= wdata;
            if (wr_frs)
                frame_format_r <= wdata[6:0];
            if (wr_spos)
                sample_pos_r <= wdata[3:0];
            if (wr_ovr)
                oversample_r <= wdata[3:0];
            if (wr_mod2)
                manual_mode_r <= wdata[0];
            if (wr_tbuf)
                tx_buf_r <= wdata;
        end
    end

    // ---------------- decoded configuration ----------------
    wire [1:0] char_sel  = frame_format_r[`FRS_CHAR_MSB:`FRS_CHAR_LSB];
    wire       two_stops = frame_format_r[`FRS_STOP_BIT];
    wire       ninth_tx  = frame_format_r[`FRS_XB9_BIT];
    wire [1:0] psel      = frame_format_r[`FRS_PSEL_MSB:`FRS_PSEL_LSB];
    wire [3:0] nbits     = (char_sel == `CHAR_LEN_8) ? 4'h8 :
                           (char_sel == `CHAR_LEN_7) ? 4'h7 : 4'h9;
    wire       loopback  = (char_sel == `CHAR_LOOPBACK);
    wire       par_on    = frame_format_r[`FRS_PEN_BIT] && (nbits != 4'h9);
    wire [4:0] rate      = os_rate(oversample_r);
    wire [3:0] last_idx  = 4'(rate - 5'h01);
    wire [3:0] auto_pos  = 4'((rate - 5'h03) >> 1);
    wire [3:0] start_pos = manual_mode_r ? sample_pos_r : auto_pos;
    wire [10:0] divisor  = {prescaler_r[`PSR_DIV_HI_MSB:`PSR_DIV_HI_LSB], baud_low_r};

    wire os_tick;

    // bit time = rate oversample ticks of (divisor+1) prescaled clocks
    uart_baud_gen #(
        .DIV_W (11),
        .PSC_W (5)
    ) u_baud (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .psc_code_i (prescaler_r[`PSR_PSC_MSB:`PSR_PSC_LSB]),
        .divisor_i  (divisor),
        .os_tick_o  (os_tick)
    );

    // ---------------- transmitter ----------------
    uart_pkg::tx_state_e tx_state_r;
    logic [3:0] tx_os_r;
    logic [3:0] tx_cnt_r;
    logic [8:0] tx_sh_r;
    logic       tx_par_r;
    logic       tx_pend_r;
    logic       txd_r;

    wire tx_bit_end = os_tick && (tx_os_r == last_idx);
    wire tx_go      = (tx_state_r == uart_pkg::TX_IDLE) && tx_pend_r && os_tick;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state_r <= uart_pkg::TX_IDLE;
            tx_os_r    <= 4'h0;
            tx_cnt_r   <= 4'h0;
            tx_sh_r    <= 9'h000;
            tx_par_r   <= 1'b0;
            tx_pend_r  <= 1'b0;
            txd_r      <= 1'b1;
        end else begin
            // a write in the start cycle re-arms, it is not lost
            tx_pend_r <= wr_tbuf | (tx_pend_r & ~tx_go);
            if (tx_state_r == uart_pkg::TX_IDLE || tx_bit_end)
                tx_os_r <= 4'h0;
            else if (os_tick)
                tx_os_r <= tx_os_r + 4'h1;
            case (tx_state_r)
                uart_pkg::TX_IDLE: begin
                    if (tx_go) begin
                        tx_sh_r    <= {ninth_tx, tx_buf_r};
                        tx_par_r   <= par_bit({ninth_tx, tx_buf_r}, nbits, psel);
                        tx_cnt_r   <= 4'h0;
                        tx_state_r <= uart_pkg::TX_START;
                    end
                end
                uart_pkg::TX_START: begin
                    if (tx_bit_end)
                        tx_state_r <= uart_pkg::TX_DATA;
                end
                uart_pkg::TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_sh_r  <= {1'b0, tx_sh_r[8:1]};
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                        if (tx_cnt_r == nbits - 4'h1) begin
                            tx_cnt_r   <= 4'h0;
                            tx_state_r <= par_on ? uart_pkg::TX_PARITY : uart_pkg::TX_STOP;
                        end
                    end
                end
                uart_pkg::TX_PARITY: begin
                    if (tx_bit_end)
                        tx_state_r <= uart_pkg::TX_STOP;
                end
                default: begin
                    if (tx_bit_end) begin
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                        if (!two_stops || tx_cnt_r != 4'h0)
                            tx_state_r <= uart_pkg::TX_IDLE;
                    end
                end
            endcase
            txd_r <= (tx_state_r == uart_pkg::TX_START)  ? 1'b0 :
                     (tx_state_r == uart_pkg::TX_DATA)   ? tx_sh_r[0] :
                     (tx_state_r == uart_pkg::TX_PARITY) ? tx_par_r : 1'b1;
        end
    end

    assign txd_o     = txd_r;
    assign tx_busy_o = (tx_state_r != uart_pkg::TX_IDLE);

    // ---------------- receiver ----------------
    logic rx_meta_r;
    logic rx_sync_r;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= rxd_i;
            rx_sync_r <= rx_meta_r;
        end
    end

    uart_pkg::rx_state_e rx_state_r;
    logic [3:0] rx_os_r;
    logic [3:0] rx_cnt_r;
    logic [8:0] rx_sh_r;
    logic       rx_done_r;
    logic       rx_perr_r;
    logic       rx_par_bad_r;
    logic       rx_ferr_r;
    logic       rx_bit;
    logic       rx_valid;

    wire rx_line = loopback ? txd_r : rx_sync_r;
    wire rx_arm  = (rx_state_r == uart_pkg::RX_IDLE) && !rx_line;
    wire [8:0] rx_data = rx_sh_r >> (4'h9 - nbits);

    uart_bit_sampler u_sampler (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .os_tick_i   (os_tick),
        .os_index_i  (rx_os_r),
        .start_i     (start_pos),
        .rxd_i       (rx_line),
        .bit_o       (rx_bit),
        .bit_valid_o (rx_valid)
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state_r <= uart_pkg::RX_IDLE;
            rx_os_r    <= 4'h0;
            rx_cnt_r   <= 4'h0;
            rx_sh_r    <= 9'h000;
            rx_buf_r   <= 8'h00;
            rx_done_r  <= 1'b0;
            rx_perr_r  <= 1'b0;
            rx_ferr_r  <= 1'b0;
            rx_par_bad_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            if (rx_arm || (os_tick && rx_os_r == last_idx))
                rx_os_r <= 4'h0;
            else if (os_tick)
                rx_os_r <= rx_os_r + 4'h1;
            case (rx_state_r)
                uart_pkg::RX_IDLE: begin
                    rx_cnt_r <= 4'h0;
                    if (rx_arm)
                        rx_state_r <= uart_pkg::RX_START;
                end
                uart_pkg::RX_START: begin
                    // a high vote means a glitch, not a start bit
                    if (rx_valid)
                        rx_state_r <= rx_bit ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                end
                uart_pkg::RX_DATA: begin
                    if (rx_valid) begin
                        rx_sh_r  <= {rx_bit, rx_sh_r[8:1]};
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r == nbits - 4'h1)
                            rx_state_r <= par_on ? uart_pkg::RX_PARITY : uart_pkg::RX_STOP;
                    end
                end
                uart_pkg::RX_PARITY: begin
                    if (rx_valid) begin
                        // held back so both error flags move together with rx_done_o
                        rx_par_bad_r <= (rx_bit != par_bit(rx_data, nbits, psel));
                        rx_state_r <= uart_pkg::RX_STOP;
                    end
                end
                default: begin
                    if (rx_valid) begin
                        rx_buf_r   <= rx_data[7:0];
                        rx_ferr_r  <= ~rx_bit;
                        rx_done_r  <= 1'b1;
                        rx_perr_r  <= par_on & rx_par_bad_r;
                        rx_state_r <= uart_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    assign rx_done_o       = rx_done_r;
    assign rx_parity_err_o = rx_perr_r;
    assign rx_frame_err_o  = rx_ferr_r;
endmodule
`default_nettype wire

// file: uart_cfg.svh
// Purpose: register map, field positions and reset values of the serial port core
// Assumes: word-indexed avalon slave, 8-bit registers in the low byte lane
// Notes:   definitions only
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

`define REG_BAUD_LOW      4'h0
`define REG_PRESCALER     4'h1
`define REG_FRAME         4'h2
`define REG_SAMPLE_POS    4'h3
`define REG_OVERSAMPLE    4'h4
`define REG_MODE_TWO      4'h5
`define REG_RX_BUF        4'h6
`define REG_TX_BUF        4'h7

`define PSR_DIV_HI_MSB    2
`define PSR_DIV_HI_LSB    0
`define PSR_PSC_MSB       7
`define PSR_PSC_LSB       3

`define FRS_CHAR_MSB      1
`define FRS_CHAR_LSB      0
`define FRS_STOP_BIT      2
`define FRS_XB9_BIT       3
`define FRS_PSEL_MSB      5
`define FRS_PSEL_LSB      4
`define FRS_PEN_BIT       6

`define FRS_RESET         7'h00
`define PSR_RESET         8'h00
`define SPOS_RESET        4'h6
`define OVR_RESET         4'h0
`define MODE_TWO_RESET    1'b0

`define OVR_MIN_CODE      4'h7
`define OVR_DEFAULT_RATE  5'h10
`define SAMPLE_SPAN       5'h02

`define CHAR_LEN_8        2'h0
`define CHAR_LEN_7        2'h1
`define CHAR_LEN_9        2'h2
`define CHAR_LOOPBACK     2'h3

`define PAR_ODD           2'h0
`define PAR_EVEN          2'h1
`define PAR_MARK          2'h2

`endif

// file: uart_pkg.sv
// Purpose: state types shared by the serial port core
// Assumes: nothing
// Notes:   no constants here, they live in uart_cfg.svh
package uart_pkg;
    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP   = 3'b100
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP   = 3'b100
    } rx_state_e;
endpackage

// file: uart_baud_gen.sv
// Purpose: two-stage baud divider producing one oversample tick per period
// Assumes: prescaler factor is (code + 2) / 2, i.e. 1.0 to 16.5 in half steps
// Notes:   the half steps come from a fractional accumulator, so tick spacing jitters by one clock
`timescale 1ns/1ps
`default_nettype none
module uart_baud_gen #(
    parameter int DIV_W = 11,
    parameter int PSC_W = 5
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic [PSC_W-1:0] psc_code_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    output logic                  os_tick_o
);
    generate
        if (DIV_W < 1 || PSC_W < 1) begin : g_bad
            $error("uart_baud_gen: widths must be positive");
        end
    endgenerate

    localparam int ACC_W = PSC_W + 2;

    logic [ACC_W-1:0] acc_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic             os_tick_r;

    // accumulate two half-units per clock, fire when a whole factor has passed
    wire [ACC_W-1:0] acc_sum  = acc_r + ACC_W'(2);
    wire [ACC_W-1:0] psc_half = ACC_W'(psc_code_i) + ACC_W'(2);
    wire             psc_tick = (acc_sum >= psc_half);
    wire             div_wrap = psc_tick && (div_cnt_r == divisor_i);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            acc_r     <= '0;
            div_cnt_r <= '0;
            os_tick_r <= 1'b0;
        end else begin
            acc_r     <= psc_tick ? acc_sum - psc_half : acc_sum;
            os_tick_r <= div_wrap;
            if (div_wrap)
                div_cnt_r <= '0;
            else if (psc_tick)
                div_cnt_r <= div_cnt_r + DIV_W'(1);
        end
    end

    assign os_tick_o = os_tick_r;
endmodule
`default_nettype wire

// file: uart_bit_sampler.sv
// Purpose: takes three consecutive oversample points in a bit and votes
// Assumes: start index + 2 lies below the oversample rate (software keeps it so)
// Notes:   bit_valid_o pulses one clock after the third sample
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg.svh"
module uart_bit_sampler (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       os_tick_i,
    input  wire logic [3:0] os_index_i,
    input  wire logic [3:0] start_i,
    input  wire logic       rxd_i,
    output logic            bit_o,
    output logic            bit_valid_o
);
    logic s0_r;
    logic s1_r;
    logic bit_r;
    logic valid_r;

    wire [4:0] idx  = {1'b0, os_index_i};
    wire [4:0] pos0 = {1'b0, start_i};
    wire       hit0 = os_tick_i && (idx == pos0);
    wire       hit1 = os_tick_i && (idx == pos0 + 5'h01);
    wire       hit2 = os_tick_i && (idx == pos0 + `SAMPLE_SPAN);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s0_r    <= 1'b1;
            s1_r    <= 1'b1;
            bit_r   <= 1'b1;
            valid_r <= 1'b0;
        end else begin
            if (hit0)
                s0_r <= rxd_i;
            if (hit1)
                s1_r <= rxd_i;
            if (hit2)
                bit_r <= (s0_r & s1_r) | (s0_r & rxd_i) | (s1_r & rxd_i);
            valid_r <= hit2;
        end
    end

    assign bit_o       = bit_r;
    assign bit_valid_o = valid_r;
endmodule
`default_nettype wire

// file: uart_frame_core_chk.sv
// Purpose: port-level timing checks of uart_frame_core
// Assumes: one wait cycle per bus access
// Notes:   watches design ports only
`timescale 1ns/1ps
`default_nettype none
module uart_frame_core_chk (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        txd_o,
    input wire logic        tx_busy_o,
    input wire logic        rx_done_o,
    input wire logic        rx_parity_err_o,
    input wire logic        rx_frame_err_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence req_s; avs_read_i || avs_write_i; endsequence
    sequence held_s; req_s ##0 avs_waitrequest_o ##1 req_s; endsequence
    a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("request not held off in its first cycle");
    a_one_wait: assert property (held_s |-> !avs_waitrequest_o)
        else $error("more than one wait cycle");
    a_wait_bound: assert property (req_s |-> ##[0:1] !avs_waitrequest_o)
        else $error("request never acknowledged");
    a_idle_free: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("wait raised without a request");
    a_rdata_high: assert property (avs_readdata_o[31:8] == 24'h0)
        else $error("read data above the byte lane");
    a_done_pulse: assert property (rx_done_o |=> !rx_done_o [*2])
        else $error("receive done longer than one cycle");
    a_start_busy: assert property ($fell(txd_o) |-> ##[0:2] tx_busy_o)
        else $error("start bit without busy");
    a_end_high: assert property ($fell(tx_busy_o) |-> txd_o)
        else $error("frame ended with line low");
    a_err_done: assert property ($changed(rx_parity_err_o) || $changed(rx_frame_err_o)
        |-> rx_done_o)
        else $error("error flag moved outside a frame end");
    a_reset_idle: assert property ($fell(rst_i) |-> txd_o && !tx_busy_o && !rx_done_o)
        else $error("line not idle after reset");
endmodule
bind uart_frame_core uart_frame_core_chk u_chk (.clk_sys_i, .rst_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .txd_o, .tx_busy_o, .rx_done_o, .rx_parity_err_o,
    .rx_frame_err_o);
`default_nettype wire

// file: remote_uart.sv
// Purpose: remote serial transceiver on the line
// Assumes: bit time in whole clocks, frames as bit vectors, start first
// Notes:   line idles high as a pulled-up serial line does
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
    input  wire logic clk_sys_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    initial rxd_o = 1'b1;
    task automatic send(input logic [12:0] b, input int n, input int t);
        for (int i = 0; i < n; i++) begin
            rxd_o <= b[i];
            repeat (t) @(posedge clk_sys_i);
        end
        rxd_o <= 1'b1;
    endtask
    // samples mid-bit, so one clock of divider jitter is tolerated
    task automatic recv(input int n, input int t, output logic [12:0] b, output bit ok);
        int k;
        b = '1;
        k = 0;
        while (txd_i !== 1'b0 && k < 20000) begin
            @(posedge clk_sys_i);
            k++;
        end
        ok = (k < 20000);
        repeat (t / 2) @(posedge clk_sys_i);
        for (int i = 0; i < n; i++) begin
            b[i] = txd_i;
            repeat (t) @(posedge clk_sys_i);
        end
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench of uart_frame_core
// Assumes: prescaler factor (code+2)/2, one wait cycle per access
// Notes:   frames are built by a model and looped through a remote transceiver
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o, rxd_i, txd_o, tx_busy_o;
    logic        rx_done_o, rx_parity_err_o, rx_frame_err_o;
    int          err_count = 0;
    int          checks_done = 0;
    int          n_done = 0;
    logic [31:0] lfsr = 32'd66479;
    logic [31:0] q;
    logic [12:0] fb;
    logic [7:0]  v;
    bit          ok;
    logic [7:0]  msk [16] = '{0: 8'hff, 1: 8'hff, 2: 8'h7f, 3: 8'h0f, 4: 8'h0f,
                              5: 8'h01, 7: 8'hff, default: 8'h00};
    logic [7:0]  bp [6] = '{8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  bo [6] = '{8'h07, 8'h07, 8'h00, 8'h06, 8'h0f, 8'h07};
    int          bt [6] = '{1799, 21, 32, 32, 30, 14};
    logic [7:0]  cf [8] = '{8'h00, 8'h55, 8'h4a, 8'h40, 8'h60, 8'h70, 8'h03, 8'h0e};
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (rx_done_o === 1'b1) n_done <= n_done + 1;
    end
    uart_frame_core u_dut (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .rxd_i, .txd_o, .tx_busy_o,
        .rx_done_o, .rx_parity_err_o, .rx_frame_err_o);
    remote_uart u_far (.clk_sys_i, .txd_i(txd_o), .rxd_o(rxd_i));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    function automatic int mk(input logic [7:0] f, input logic [8:0] d, output logic [12:0] b);
        int   nd;
        int   n;
        logic p;
        nd = (f[1:0] == 2'h1) ? 7 : (f[1:0] == 2'h0) ? 8 : 9;
        b = '1;
        b[0] = 1'b0;
        p = 1'b0;
        for (int i = 0; i < nd; i++) begin
            b[i + 1] = d[i];
            p ^= d[i];
        end
        n = nd + 1;
        if (f[6] && nd != 9) begin
            b[n] = f[5] ? ~f[4] : p ^ ~f[4];
            n++;
        end
        return n + 1 + f[2];
    endfunction
    task finish_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address_i   <= a;
        avs_writedata_i <= {24'h0, d};
        avs_read_i      <= ~w;
        avs_write_i     <= w;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20) begin
            err_count++;
            finish_test();
        end
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] f, input int t, input int bad,
                        input logic pe, input logic fe);
        logic [8:0]  d;
        logic [12:0] b;
        int          n, n0, k;
        d = {f[3], rnd()};
        n = mk(f, d, b);
        n0 = n_done;
        bus(1'b1, `REG_FRAME, f);
        bus(1'b1, `REG_TX_BUF, d[7:0]);
        u_far.recv(n, t, fb, ok);
        `CHK(ok, 1'b1)
        `CHK(fb, b)
        `CHK(tx_busy_o, 1'b0)
        if (f[1:0] != 2'h3) begin
            if (bad > 0) b[bad] = ~b[bad];
            n0 = n_done;
            u_far.send(b, n, t);
        end
        k = 0;
        while (n_done == n0 && k < 100) begin
            @(posedge clk_sys_i);
            k++;
        end
        `CHK(n_done, n0 + 1)
        if (!ok || k >= 100) finish_test();
        `CHK(rx_parity_err_o, pe)
        `CHK(rx_frame_err_o, fe)
        bus(1'b1, `REG_RX_BUF, ~d[7:0]);
        bus(1'b0, `REG_RX_BUF, 8'h0);
        `CHK(q, {24'h0, d[7:0] & ((f[1:0] == 2'h1) ? 8'h7f : 8'hff)})
        bus(1'b0, `REG_TX_BUF, 8'h0);
        `CHK(q, {24'h0, d[7:0]})
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 1; i < 10; i++) begin
            if (i != 6 && i != 8) begin
                bus(1'b0, i[3:0], 8'h0);
                `CHK(q, (i == 3) ? 32'h6 : 32'h0)
            end
        end
        // the transmit buffer is left out: a write would start a frame at a random rate
        for (int i = 0; i < 16; i++) begin
            if (i != 7) begin
                v = rnd();
                bus(1'b1, i[3:0], v);
                bus(1'b0, i[3:0], 8'h0);
                `CHK(q, {24'h0, v & msk[i]})
            end
        end
        bus(1'b1, `REG_BAUD_LOW, 8'h5a);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        bus(1'b0, `REG_BAUD_LOW, 8'h0);
        `CHK(q, 32'h5a)
        bus(1'b1, `REG_MODE_TWO, 8'h00);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `REG_PRESCALER, bp[i]);
            bus(1'b1, `REG_BAUD_LOW, (i == 0) ? 8'h00 : 8'h01);
            bus(1'b1, `REG_OVERSAMPLE, bo[i]);
            xfer(8'h00, bt[i], 0, 1'b0, 1'b0);
        end
        bus(1'b1, `REG_SAMPLE_POS, 8'h03);
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, `REG_MODE_TWO, m[7:0]);
            for (int i = 0; i < 8; i++) xfer(cf[i], 14, 0, 1'b0, 1'b0);
        end
        xfer(8'h40, 14, 9, 1'b1, 1'b0);
        xfer(8'h40, 14, 10, 1'b0, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
